// [design/scc_pkg.sv]
// Package: constants, states and carriers of the SPI command checker
package scc_pkg;

   // ----------------------------------------
   // Frame layout
   // ----------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int ADDR_LSB = 0;
   localparam int ADDR_MSB = 6;
   localparam int RW_BIT = 7;
   localparam int DATA_LSB = 8;
   localparam int DATA_MSB = 15;
   localparam logic [4:0] CLK_COUNT_EMPTY = 5'h00;
   localparam logic [4:0] CLK_COUNT_FULL = 5'h10;

   // ----------------------------------------
   // Register addresses
   // ----------------------------------------
   localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
   localparam logic [6:0] ADDR_WATCHDOG_CTRL = 7'h02;
   localparam logic [6:0] ADDR_BUS_CTRL = 7'h03;
   localparam logic [6:0] ADDR_WAKE_ENABLE_CTRL = 7'h04;
   localparam logic [6:0] ADDR_TIMER_PERIOD = 7'h0c;
   localparam logic [6:0] ADDR_TIMER_ON = 7'h0d;
   localparam logic [6:0] ADDR_STATUS_BASE = 7'h40;
   localparam logic [6:0] ADDR_DEVICE_STAT = 7'h43;
   localparam logic [6:0] ADDR_WAKE_STAT_FIRST = 7'h46;
   localparam logic [6:0] ADDR_WAKE_STAT_SECOND = 7'h47;

   // ----------------------------------------
   // Mode control field (data byte)
   // ----------------------------------------
   localparam int MODE_LSB = 6;
   localparam int LOAD_SHARE_BIT = 2;
   localparam logic [1:0] REQ_NORMAL = 2'h0;
   localparam logic [1:0] REQ_SLEEP = 2'h1;
   localparam logic [1:0] REQ_STOP = 2'h2;
   localparam logic [1:0] REQ_SOFT_RESET = 2'h3;
   localparam int FAIL_BIT = 0;

   // Wake enable control bits
   localparam int WAKE_ONE_BIT = 0;
   localparam int WAKE_TWO_BIT = 1;
   localparam int WAKE_TIMER_BIT = 3;
   localparam int WAKE_MEAS_BIT = 7;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] RST_MODE_CTRL = 8'h00;
   localparam logic [7:0] RST_WATCHDOG = 8'h15;
   localparam logic [7:0] RST_BUS_CTRL = 8'h00;
   localparam logic [7:0] RST_WAKE_CTRL = 8'h01;
   localparam logic [7:0] RST_TIMER = 8'h00;

   // Three-stage pin synchroniser depth
   localparam int SYNC_STAGES = 3;

   // ----------------------------------------
   // Device modes, Gray along init-normal-stop-sleep
   // ----------------------------------------
   typedef enum logic [2:0] {
      SCC_INIT    = 3'b000,
      SCC_NORMAL  = 3'b001,
      SCC_STOP    = 3'b011,
      SCC_SLEEP   = 3'b010,
      SCC_RESTART = 3'b110
   } scc_mode_t;

   // Received command word
   typedef struct packed {
      logic [7:0] data;
      logic       write;
      logic [6:0] addr;
   } scc_cmd_t;

   // Serial pin group
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic serial_data_in;
   } scc_pins_t;

endpackage

// [design/scc_top.sv]
// SPI slave port with command checking and error signalling
//
// Notes on behaviour
// - One 16-bit word in, one word out.
// - Frame spans chip select low to high.
// - At rise, interpret word, release serial output.
// - Sample on falling edge, shift after rising.
// - No pass-through; not daisy-chain capable.
// - Bad write ignored, sticky failure flag set.
// - Stop to Sleep: fail, go Restart.
// - Stop/Sleep from Init: fail, go Normal.
// - Watchdog byte uneven parity: ignore, fail.
// - Stop mode accepts only few commands.
// - Stop with wake status set: interrupt.
// - Stop to Normal with extras: mode only.
// - Sleep without wake sources: fail, Restart.
// - Timer only wake, timer off: Restart.
// - Stop without wake sources accepted silently.
// - Load sharing stays set, clearing flagged.
// - Sleep with measure and wake pins: fail, Restart.
// - Timer on-time not below period: fail.
// - All zeros or ones word: fail.
// - Bad clock count: discard, error bit next.
// - Frame during reset low: error, output high.
// - Address 6:0, access bit 7, data 15:8.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Accepted command FIFO
// ----------------------------------------
module scc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic do_wr;
   logic do_rd;

   assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];
   assign do_wr = in_valid & in_ready;
   assign do_rd = out_valid & out_ready;

   always_ff @(posedge sys_clk) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // scc_fifo

// ----------------------------------------
// Top level
// ----------------------------------------
module scc_top #(
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Serial link pins
   input wire scc_pkg::scc_pins_t pins,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   // Device state
   input wire logic reset_output_n,
   input wire logic [7:0] wake_status_first,
   input wire logic [7:0] wake_status_second,
   input wire logic clear_wake_status,
   // Results
   output scc_pkg::scc_mode_t mode,
   output logic cmd_fail,
   output logic interrupt_pulse,
   output logic [7:0] watchdog_control_reg,
   output logic watchdog_trigger,
   output logic [7:0] wake_enable_control_reg,
   output logic regulator_load_sharing,
   output logic frame_error,
   // Accepted command stream
   output scc_pkg::scc_cmd_t cmd_data,
   output logic cmd_valid,
   input wire logic cmd_ready
);
   import scc_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [SYNC_STAGES-1:0] sync_cs;
   logic [SYNC_STAGES-1:0] sync_clk;
   logic [SYNC_STAGES-1:0] sync_sdi;
   logic [SYNC_STAGES-1:0] sync_ro;
   logic cs_n;
   logic sclk;
   logic ro_n;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         sync_cs <= '1;
         sync_clk <= '0;
         sync_sdi <= '0;
         sync_ro <= '1;
      end else begin
         sync_cs <= {sync_cs[SYNC_STAGES-2:0], pins.cs_n};
         sync_clk <= {sync_clk[SYNC_STAGES-2:0], pins.sclk};
         sync_sdi <= {sync_sdi[SYNC_STAGES-2:0], pins.serial_data_in};
         sync_ro <= {sync_ro[SYNC_STAGES-2:0], reset_output_n};
      end
   end

   // Change counts once stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cs_n <= 1'b1;
         sclk <= 1'b0;
         ro_n <= 1'b1;
      end else begin
         if (sync_cs[1] == sync_cs[2]) begin
            cs_n <= sync_cs[2];
         end
         if (sync_clk[1] == sync_clk[2]) begin
            sclk <= sync_clk[2];
         end
         if (sync_ro[1] == sync_ro[2]) begin
            ro_n <= sync_ro[2];
         end
      end
   end

   logic cs_n_d;
   logic sclk_d;
   logic cs_fall;
   logic cs_rise;
   logic clk_rise;
   logic clk_fall;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cs_n_d <= 1'b1;
         sclk_d <= 1'b0;
      end else begin
         cs_n_d <= cs_n;
         sclk_d <= sclk;
      end
   end

   assign cs_fall = cs_n_d & ~cs_n;
   assign cs_rise = ~cs_n_d & cs_n;
   assign clk_rise = ~cs_n & ~sclk_d & sclk;
   assign clk_fall = ~cs_n & sclk_d & ~sclk;

   // ----------------------------------------
   // Frame shifting
   // ----------------------------------------
   logic [15:0] rx_shift;
   logic [15:0] tx_shift;
   logic [4:0] clk_count;
   logic clk_high_edge;
   logic ro_seen;
   logic err_pending;
   logic [7:0] status_byte;

   assign status_byte = {4'h0, 1'b0, mode};

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         rx_shift <= '0;
         clk_count <= '0;
      end else if (cs_fall) begin
         rx_shift <= '0;
         clk_count <= '0;
      end else if (clk_fall) begin
         rx_shift <= {sync_sdi[2], rx_shift[15:1]};
         if (clk_count != 5'h1f) begin
            clk_count <= clk_count + 5'h01;
         end
      end
   end

   // Only own response shifts out, never received bits
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         tx_shift <= '0;
      end else if (cs_fall) begin
         tx_shift <= {7'h00, cmd_fail, status_byte};
         tx_shift[0] <= err_pending;
      end else if (clk_rise) begin
         tx_shift <= {1'b0, tx_shift[15:1]};
      end
   end

   // Clock high at either select edge spoils the frame
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         clk_high_edge <= 1'b0;
         ro_seen <= 1'b0;
      end else if (cs_fall) begin
         clk_high_edge <= sclk;
         ro_seen <= ~ro_n;
      end else if (!cs_n && !ro_n) begin
         ro_seen <= 1'b1;
      end
   end

   logic frame_bad;
   assign frame_bad = (clk_count != CLK_COUNT_EMPTY && clk_count != CLK_COUNT_FULL)
                      || clk_high_edge || sclk || ro_seen || !ro_n;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         err_pending <= 1'b0;
      end else if (cs_rise) begin
         err_pending <= frame_bad;
      end
   end

   // Output driven only inside a frame; forced high while reset_output_n is low
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         serial_data_out <= 1'b0;
         serial_data_out_oe <= 1'b0;
      end else begin
         serial_data_out_oe <= ~cs_n;
         serial_data_out <= !ro_n ? 1'b1 : tx_shift[0];
      end
   end

   // ----------------------------------------
   // Command checking
   // ----------------------------------------
   scc_cmd_t cmd;
   logic word_ok;
   logic do_write;
   logic stuck;
   logic [1:0] req;
   logic no_wake;
   logic [7:0] timer_period;
   logic [7:0] timer_on;
   logic [7:0] mode_ctrl;
   logic [7:0] bus_ctrl;
   logic wake_pending;

   assign cmd = scc_cmd_t'(rx_shift);
   assign stuck = (rx_shift == 16'h0000) || (rx_shift == 16'hffff);
   assign word_ok = cs_rise && !frame_bad && clk_count == CLK_COUNT_FULL && mode != SCC_RESTART;
   assign do_write = word_ok && cmd.write && cmd.addr < ADDR_STATUS_BASE;
   assign req = cmd.data[MODE_LSB+1:MODE_LSB];
   assign no_wake = (bus_ctrl == 8'h00) && (wake_enable_control_reg[6:0] == 7'h00);
   assign wake_pending = (wake_status_first != 8'h00) || (wake_status_second != 8'h00);

   logic fail_set;
   scc_mode_t next_mode;
   logic next_fail;
   logic apply;

   always_comb begin
      next_mode = mode;
      next_fail = 1'b0;
      apply = do_write && !stuck;
      if (word_ok && stuck) begin
         next_fail = 1'b1;
      end else if (do_write && mode == SCC_STOP
                   && cmd.addr != ADDR_MODE_CTRL && cmd.addr != ADDR_WATCHDOG_CTRL) begin
         next_fail = 1'b1;
         apply = 1'b0;
      end else if (do_write && cmd.addr == ADDR_WATCHDOG_CTRL && ^cmd.data) begin
         next_fail = 1'b1;
         apply = 1'b0;
      end else if (do_write && cmd.addr == ADDR_TIMER_ON && cmd.data >= timer_period) begin
         next_fail = 1'b1;
         apply = 1'b0;
      end else if (do_write && cmd.addr == ADDR_MODE_CTRL) begin
         if (req == REQ_SOFT_RESET) begin
            next_mode = SCC_RESTART;
         end else if (mode == SCC_INIT && (req == REQ_STOP || req == REQ_SLEEP)) begin
            next_fail = 1'b1;
            next_mode = SCC_NORMAL;
            apply = 1'b0;
         end else if (mode == SCC_STOP && req == REQ_SLEEP) begin
            next_fail = 1'b1;
            next_mode = SCC_RESTART;
            apply = 1'b0;
         end else if (mode == SCC_STOP && req == REQ_NORMAL) begin
            next_mode = SCC_NORMAL;
            next_fail = cmd.data[MODE_LSB-1:0] != mode_ctrl[MODE_LSB-1:0];
            apply = 1'b0;
         end else if (mode == SCC_STOP) begin
            next_fail = 1'b1;
            apply = 1'b0;
         end else if (req == REQ_SLEEP && no_wake) begin
            next_fail = 1'b1;
            next_mode = SCC_RESTART;
         end else if (req == REQ_SLEEP && wake_enable_control_reg[WAKE_MEAS_BIT]
                      && (wake_enable_control_reg[WAKE_ONE_BIT] || wake_enable_control_reg[WAKE_TWO_BIT])
                      && wake_enable_control_reg[6:2] == 5'h00 && bus_ctrl == 8'h00) begin
            next_fail = 1'b1;
            next_mode = SCC_RESTART;
         end else if (req == REQ_SLEEP && wake_enable_control_reg[6:0] == 7'h08
                      && bus_ctrl == 8'h00 && timer_period == 8'h00) begin
            next_mode = SCC_RESTART;
         end else if (req == REQ_SLEEP) begin
            next_mode = SCC_SLEEP;
         end else if (req == REQ_STOP) begin
            next_mode = SCC_STOP;
         end else begin
            next_mode = SCC_NORMAL;
         end
         if (mode_ctrl[LOAD_SHARE_BIT] && !cmd.data[LOAD_SHARE_BIT] && mode != SCC_STOP) begin
            next_fail = 1'b1;
         end
      end
   end

   assign fail_set = next_fail;

   // Sticky flag: set beats a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cmd_fail <= 1'b0;
      end else if (fail_set) begin
         cmd_fail <= 1'b1;
      end else if (word_ok && cmd.write && cmd.addr == ADDR_DEVICE_STAT && cmd.data[FAIL_BIT]) begin
         cmd_fail <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mode <= SCC_INIT;
      end else if (!ro_n) begin
         mode <= SCC_RESTART;
      end else if (mode == SCC_RESTART) begin
         mode <= SCC_NORMAL;
      end else if (word_ok) begin
         mode <= next_mode;
      end
   end

   // Writes are applied whole or not at all, except that a set load-sharing bit in mode control stays set
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         mode_ctrl <= RST_MODE_CTRL;
         watchdog_control_reg <= RST_WATCHDOG;
         bus_ctrl <= RST_BUS_CTRL;
         wake_enable_control_reg <= RST_WAKE_CTRL;
         timer_period <= RST_TIMER;
         timer_on <= RST_TIMER;
      end else if (apply) begin
         case (cmd.addr)
            ADDR_MODE_CTRL: begin
               mode_ctrl <= cmd.data | (mode_ctrl & (8'h01 << LOAD_SHARE_BIT));
            end
            ADDR_WATCHDOG_CTRL: watchdog_control_reg <= cmd.data;
            ADDR_BUS_CTRL: bus_ctrl <= cmd.data;
            ADDR_WAKE_ENABLE_CTRL: wake_enable_control_reg <= cmd.data;
            ADDR_TIMER_PERIOD: timer_period <= cmd.data;
            ADDR_TIMER_ON: timer_on <= cmd.data;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         regulator_load_sharing <= 1'b0;
         watchdog_trigger <= 1'b0;
         interrupt_pulse <= 1'b0;
         frame_error <= 1'b0;
      end else begin
         regulator_load_sharing <= mode_ctrl[LOAD_SHARE_BIT];
         watchdog_trigger <= apply && cmd.addr == ADDR_WATCHDOG_CTRL;
         interrupt_pulse <= word_ok && next_mode == SCC_STOP && mode != SCC_STOP
                            && wake_pending && !clear_wake_status;
         frame_error <= err_pending;
      end
   end

   // ----------------------------------------
   // Accepted command stream
   // ----------------------------------------
   logic fifo_ready;
   scc_cmd_t fifo_out;
   logic fifo_valid;

   scc_fifo #(
      .WIDTH(FRAME_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .in_data(rx_shift),
      .in_valid(word_ok && !stuck),
      .in_ready(fifo_ready),
      .out_data(fifo_out),
      .out_valid(fifo_valid),
      .out_ready(cmd_ready && !cmd_valid)
   );

   // Words lost when full; fifo_ready is not reported upstream, not even via status
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         cmd_valid <= 1'b0;
         cmd_data <= '0;
      end else if (fifo_valid && cmd_ready && !cmd_valid) begin
         cmd_valid <= 1'b1;
         cmd_data <= fifo_out;
      end else begin
         cmd_valid <= 1'b0;
      end
   end

endmodule // scc_top
`default_nettype wire

// [dv/scc_checker_props.sv]
// Concurrent checks on the ports of the SPI command checker
`timescale 1ns/1ns
`default_nettype none
module scc_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Serial link and device state
   input wire scc_pkg::scc_pins_t pins,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   input wire logic reset_output_n,
   // Results
   input wire scc_pkg::scc_mode_t mode,
   input wire logic cmd_fail,
   input wire logic interrupt_pulse,
   input wire logic [7:0] watchdog_control_reg
);
   import scc_pkg::*;
   // ----
   // Cycles since the last chip select rise, saturating
   // ----
   logic [4:0] since_rise;
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         since_rise <= 5'h1f;
      end else if ($rose(pins.cs_n)) begin
         since_rise <= 5'h00;
      end else if (since_rise != 5'h1f) begin
         since_rise <= since_rise + 5'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence cs_rise_s;
      $rose(pins.cs_n);
   endsequence
   sequence cs_fall_s;
      $fell(pins.cs_n) && reset_output_n;
   endsequence
   // ----
   // Properties
   // ----
   AST_RELEASE_AFTER_FRAME: assert property (cs_rise_s |-> ##[1:10] !serial_data_out_oe)
      else $error("serial output still driven after frame end");
   AST_DRIVE_IN_FRAME: assert property (cs_fall_s |-> ##[2:10] serial_data_out_oe)
      else $error("serial output not driven after frame start");
   AST_HOLD_IN_FRAME: assert property ((!pins.cs_n)[*8] |-> serial_data_out_oe)
      else $error("serial output dropped inside frame");
   AST_HIGH_IN_RESET: assert property ((!reset_output_n)[*6] |-> serial_data_out)
      else $error("serial output low while reset line low");
   AST_FAIL_AFTER_FRAME: assert property ($changed(cmd_fail) |-> since_rise <= 5'h0c)
      else $error("failure flag moved outside a frame end");
   AST_SETTING_AFTER_FRAME: assert property ($changed(watchdog_control_reg) |-> since_rise <= 5'h0c)
      else $error("watchdog setting moved outside a frame end");
   AST_IRQ_ON_STOP: assert property ($rose(interrupt_pulse) |-> ##[0:2] (mode == SCC_STOP))
      else $error("interrupt without stop entry");
   AST_NO_STOP_TO_SLEEP: assert property (mode == SCC_STOP |=> mode != SCC_SLEEP)
      else $error("stop went straight to sleep");
   AST_NO_LOW_POWER_FROM_INIT: assert property (mode == SCC_INIT |=> !(mode inside {SCC_STOP, SCC_SLEEP}))
      else $error("low power mode entered from init");
endmodule // scc_checker
`default_nettype wire

// [dv/scc_master_model.sv]
// Microcontroller model: SPI bus master
`timescale 1ns/1ns
`default_nettype none
module scc_master_model (
   // Serial link
   output var scc_pkg::scc_pins_t pins,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe
);
   import scc_pkg::*;
   localparam int HALF_NS = 400;
   initial begin
      pins = '0;
      pins.cs_n = 1'b1;
   end
   // Released output reads as unknown, so it never passes a compare
   function automatic logic line();
      return (serial_data_out_oe === 1'b1) ? serial_data_out : 1'bx;
   endfunction
   task automatic xfer(input logic [15:0] word, input int nclk, input bit clk_hi, output logic [15:0] resp);
      resp = '0;
      #37;
      pins.sclk = clk_hi;
      pins.cs_n = 1'b0;
      #(HALF_NS);
      pins.sclk = 1'b0;
      #(2 * HALF_NS);
      resp[0] = line();
      for (int i = 0; i < nclk; i++) begin
         pins.serial_data_in = word[i];
         #(HALF_NS / 2);
         resp[i] = line();
         pins.sclk = 1'b1;
         #(HALF_NS);
         pins.sclk = 1'b0;
         #(HALF_NS / 2);
      end
      #(HALF_NS);
      pins.cs_n = 1'b1;
      pins.serial_data_in = ~pins.serial_data_in;
      #(2 * HALF_NS);
   endtask
endmodule // scc_master_model
`default_nettype wire

// [dv/scc_top_test.sv]
// Testbench for the SPI command checker
`timescale 1ns/1ns
`default_nettype none
module scc_top_test;
   import scc_pkg::*;
   localparam int DEPTH = 16;
   logic sys_clk, rst_b, serial_data_out, serial_data_out_oe, reset_output_n, clear_wake_status;
   logic cmd_fail, interrupt_pulse, watchdog_trigger, regulator_load_sharing, frame_error, cmd_valid, cmd_ready;
   logic [7:0] wake_status_first, wake_status_second, watchdog_control_reg, wake_enable_control_reg;
   logic [15:0] resp;
   scc_pins_t pins;
   scc_mode_t mode;
   scc_cmd_t cmd_data;
   int failures, n_checks, n_irq, n_restart, n_wdt;
   scc_top #(.FIFO_DEPTH(DEPTH)) i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .pins(pins),
      .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
      .reset_output_n(reset_output_n), .wake_status_first(wake_status_first),
      .wake_status_second(wake_status_second), .clear_wake_status(clear_wake_status), .mode(mode),
      .cmd_fail(cmd_fail), .interrupt_pulse(interrupt_pulse), .watchdog_control_reg(watchdog_control_reg),
      .watchdog_trigger(watchdog_trigger), .wake_enable_control_reg(wake_enable_control_reg),
      .regulator_load_sharing(regulator_load_sharing), .frame_error(frame_error), .cmd_data(cmd_data),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));
   scc_master_model i_master (.pins(pins), .serial_data_out(serial_data_out),
      .serial_data_out_oe(serial_data_out_oe));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (interrupt_pulse === 1'b1) n_irq++;
      if (mode === SCC_RESTART) n_restart++;
      if (watchdog_trigger === 1'b1) n_wdt++;
   end
   // ----
   // Shared tasks
   // ----
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   function automatic logic [15:0] wr(input logic [6:0] a, input logic [7:0] d);
      return {d, 1'b1, a};
   endfunction
   function automatic logic [15:0] md(input logic [1:0] r);
      return wr(ADDR_MODE_CTRL, {r, 6'h04});
   endfunction
   task automatic send(input logic [15:0] w, input int n = 16);
      i_master.xfer(w, n, 1'b0, resp);
   endtask
   task automatic expect_state(input scc_mode_t m, input logic f);
      check("mode", 16'(mode), 16'(m));
      check("cmd_fail", 16'(cmd_fail), 16'(f));
   endtask
   task automatic clear_fail;
      send(wr(ADDR_DEVICE_STAT, 8'h01));
      check("fail_in_resp", 16'(resp[8]), 16'h0001);
      check("cmd_fail", 16'(cmd_fail), 16'h0000);
   endtask
   task automatic sleep_fails;
      n_restart = 0;
      send(md(REQ_SLEEP));
      expect_state(SCC_NORMAL, 1'b1);
      check("restart_seen", 16'(n_restart > 0), 16'h0001);
      clear_fail();
   endtask
   task automatic share(input logic exp);
      check("load_share", 16'(regulator_load_sharing), 16'(exp));
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_fifo;
      int n;
      check("oe", 16'(serial_data_out_oe), 16'h0000);
      check("wd", 16'(watchdog_control_reg), 16'(RST_WATCHDOG));
      for (int i = 0; i <= DEPTH; i++) begin
         send({8'(i), 1'b0, ADDR_DEVICE_STAT});
      end
      n = 0;
      repeat (100) begin
         @(posedge sys_clk);
         if (cmd_valid === 1'b1) begin
            check("cmd_data", cmd_data, {8'(n), 1'b0, ADDR_DEVICE_STAT});
            n++;
         end
         cmd_ready <= ~cmd_ready;
      end
      check("drained", 16'(n), 16'(DEPTH));
      cmd_ready <= 1'b1;
   endtask
   task automatic t_faults;
      logic [15:0] w [2] = '{16'h0000, 16'hffff};
      send(md(REQ_STOP));
      expect_state(SCC_NORMAL, 1'b1);
      clear_fail();
      n_wdt = 0;
      send(wr(ADDR_WATCHDOG_CTRL, 8'h01));
      check("wd", 16'(watchdog_control_reg), 16'(RST_WATCHDOG));
      clear_fail();
      send(wr(ADDR_WATCHDOG_CTRL, 8'h03));
      check("wd", 16'(watchdog_control_reg), 16'h0003);
      check("wd_trig", 16'(n_wdt), 16'h0001);
      foreach (w[k]) begin
         send(w[k]);
         check("cmd_fail", 16'(cmd_fail), 16'h0001);
         clear_fail();
      end
      for (int k = 0; k < 2; k++) begin
         i_master.xfer(wr(ADDR_WAKE_ENABLE_CTRL, 8'h03), k ? 16 : 8, 1'(k), resp);
         check("wake", 16'(wake_enable_control_reg), 16'(RST_WAKE_CTRL));
         check("frame_error", 16'(frame_error), 16'h0001);
         send(16'h0000, 0);
         check("err_bit", 16'(resp[0]), 16'h0001);
      end
   endtask
   task automatic t_stop;
      @(posedge sys_clk);
      wake_status_first <= 8'h01;
      n_irq = 0;
      send(md(REQ_STOP));
      expect_state(SCC_STOP, 1'b0);
      check("irq", 16'(n_irq), 16'h0001);
      @(posedge sys_clk);
      wake_status_first <= 8'h00;
      send(wr(ADDR_WAKE_ENABLE_CTRL, 8'h03));
      check("wake", 16'(wake_enable_control_reg), 16'(RST_WAKE_CTRL));
      expect_state(SCC_STOP, 1'b1);
      clear_fail();
      send(wr(ADDR_MODE_CTRL, 8'h00));
      expect_state(SCC_NORMAL, 1'b1);
      share(1'b1);
      clear_fail();
      send(md(REQ_STOP));
      sleep_fails();
   endtask
   task automatic t_wake;
      send(md(REQ_NORMAL));
      share(1'b1);
      send(wr(ADDR_MODE_CTRL, 8'h00));
      share(1'b1);
      expect_state(SCC_NORMAL, 1'b1);
      clear_fail();
      send(wr(ADDR_WAKE_ENABLE_CTRL, 8'h00));
      send(md(REQ_STOP));
      expect_state(SCC_STOP, 1'b0);
      send(md(REQ_NORMAL));
      sleep_fails();
      share(1'b1);
      send(wr(ADDR_WAKE_ENABLE_CTRL, 8'h81));
      sleep_fails();
      send(wr(ADDR_TIMER_PERIOD, 8'h05));
      send(wr(ADDR_TIMER_ON, 8'h05));
      check("cmd_fail", 16'(cmd_fail), 16'h0001);
      clear_fail();
      send(wr(ADDR_TIMER_PERIOD, 8'h00));
      send(wr(ADDR_WAKE_ENABLE_CTRL, 8'h08));
      n_restart = 0;
      send(md(REQ_SLEEP));
      expect_state(SCC_NORMAL, 1'b0);
      check("restart_seen", 16'(n_restart > 0), 16'h0001);
      fork
         send(md(REQ_NORMAL));
         begin
            repeat (40) @(posedge sys_clk);
            reset_output_n <= 1'b0;
            repeat (20) @(posedge sys_clk);
            reset_output_n <= 1'b1;
         end
      join
      send(16'h0000, 0);
      check("err_bit", 16'(resp[0]), 16'h0001);
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      rst_b = 1'b0;
      reset_output_n = 1'b1;
      clear_wake_status = 1'b0;
      wake_status_first = 8'h00;
      wake_status_second = 8'h00;
      cmd_ready = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge sys_clk);
      t_fifo();
      t_faults();
      t_stop();
      t_wake();
      close_out();
   end
   initial begin
      #3000000;
      failures++;
      close_out();
   end
endmodule // scc_top_test
bind scc_top scc_checker i_chk (.sys_clk(sys_clk), .rst_b(rst_b), .pins(pins), .serial_data_out(serial_data_out),
   .serial_data_out_oe(serial_data_out_oe), .reset_output_n(reset_output_n), .mode(mode), .cmd_fail(cmd_fail),
   .interrupt_pulse(interrupt_pulse), .watchdog_control_reg(watchdog_control_reg));
`default_nettype wire
